//--- rtb_timer.sv
// Reload timer with serial baud selects, Avalon-MM slave
//
// Chosen here: the Avalon-MM interface to the registers.
module rtb_timer (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [9:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             irq,
    input  wire logic        timer_int_enable,
    input  wire logic        isr_enter,
    output logic             timer_int_request,
    input  wire logic        timer1_baud_tick,
    output logic             port0_baud_tick,
    output logic             port0_baud_source_select,
    input  wire logic [1:0]  port1_mode,
    output logic             port1_double_baud,
    output logic             port1_double_active,
    output logic             port1_frame_error_access,
    input  wire logic        port1_mode_bit_zero,
    input  wire logic        port1_framing_error,
    output logic             port1_ctrl_bit7
);
    // Control and reload storage
    logic [7:0]  ctrl_ff;
    logic [7:0]  nxt_ctrl;
    logic [7:0]  reload_low_byte_ff;
    logic [7:0]  reload_high_byte_ff;
    logic        overflow_flag_ff;
    logic        nxt_overflow_flag;
    logic        irq_status_ff;
    logic        nxt_irq_status;
    logic        irq_mask_ff;
    logic        ack_ff;
    logic [31:0] readdata_ff;
    logic [31:0] nxt_readdata;
    logic        nxt_ack;
    logic        nxt_irq_mask;
    logic [7:0]  nxt_reload_low;
    logic [7:0]  nxt_reload_high;

    // Bus decode
    logic [7:0]  idx;
    logic        req;
    logic        wr_take;
    logic        rd_take;
    logic        lane0;
    logic        hit_ctrl;
    logic        hit_rl;
    logic        hit_rh;
    logic        hit_cl;
    logic        hit_ch;
    logic        hit_st;
    logic        hit_mk;
    logic        wr_ctrl;
    logic        wr_rl;
    logic        wr_rh;
    logic        wr_mk;
    logic        clr_status;
    logic        rd_capture;
    logic [7:0]  rd_ctrl_byte;
    logic [7:0]  rd_status_byte;
    logic [7:0]  rd_mask_byte;
    logic [7:0]  rd_byte;

    // Timer datapath
    logic [15:0] count;
    logic        overflow;
    logic        timer_run;
    logic [2:0]  prescale_select;

    rtb_presc_if pif ();

    // One wait cycle, then answer; writes and read clears act at the released edge
    assign req         = read | write;
    assign waitrequest = req & ~ack_ff;
    assign wr_take     = write & ack_ff;
    assign rd_take     = read & ack_ff;
    assign idx         = address[9:2];
    assign lane0       = byteenable[0];
    assign hit_ctrl    = (idx == rtb_pkg::IDX_TIMER_CONTROL);
    assign hit_rl      = (idx == rtb_pkg::IDX_RELOAD_LOW);
    assign hit_rh      = (idx == rtb_pkg::IDX_RELOAD_HIGH);
    assign hit_cl      = (idx == rtb_pkg::IDX_COUNT_LOW);
    assign hit_ch      = (idx == rtb_pkg::IDX_COUNT_HIGH);
    assign hit_st      = (idx == rtb_pkg::IDX_IRQ_STATUS);
    assign hit_mk      = (idx == rtb_pkg::IDX_IRQ_MASK);

    // Control fields
    assign timer_run       = ctrl_ff[rtb_pkg::POS_RUN];
    assign prescale_select = ctrl_ff[rtb_pkg::POS_PRESCALE +: rtb_pkg::PRESCALE_W];
    assign pif.run         = timer_run;
    assign pif.sel         = prescale_select;

    rtb_prescaler u_presc (
        .clock  (clock),
        .resetn (resetn),
        .pif    (pif)
    );

    // Reload value assembled from the two bytes
    rtb_counter #(.WIDTH(rtb_pkg::COUNT_W)) u_cnt (
        .clock    (clock),
        .resetn   (resetn),
        .tick     (pif.tick),
        .reload   ({reload_high_byte_ff, reload_low_byte_ff}),
        .count    (count),
        .overflow (overflow)
    );

    // Write strobes fire only at the released edge; lane 0 carries the byte
    assign wr_ctrl    = wr_take & hit_ctrl & lane0;
    assign wr_rl      = wr_take & hit_rl & lane0;
    assign wr_rh      = wr_take & hit_rh & lane0;
    assign wr_mk      = wr_take & hit_mk & lane0;
    assign clr_status = rd_take & hit_st;
    assign rd_capture = read & ~ack_ff;

    // Control byte write; flag bit kept separately
    assign nxt_ctrl = wr_ctrl ? writedata[7:0] : ctrl_ff;

    // Hardware set beats software and service-entry clear
    assign nxt_overflow_flag =
        overflow ? 1'b1 :
        wr_ctrl ? writedata[rtb_pkg::POS_OVF_FLAG] :
        isr_enter ? 1'b0 : overflow_flag_ff;

    // Sticky event bit, cleared by a status read unless set in the same cycle
    assign nxt_irq_status = overflow | (irq_status_ff & ~clr_status);

    // Mask and reload bytes hold unless their own strobe fires
    assign nxt_irq_mask    = wr_mk ? writedata[0] : irq_mask_ff;
    assign nxt_reload_low  = wr_rl ? writedata[7:0] : reload_low_byte_ff;
    assign nxt_reload_high = wr_rh ? writedata[7:0] : reload_high_byte_ff;

    // One wait cycle, then one answered cycle, even for back-to-back requests
    assign nxt_ack = req & ~ack_ff;

    // Readback bytes; the flag shows its live value, not the stored control bit
    assign rd_ctrl_byte   = {ctrl_ff[7:rtb_pkg::POS_OVF_FLAG + 1], overflow_flag_ff,
                             ctrl_ff[rtb_pkg::POS_OVF_FLAG - 1:0]};
    assign rd_status_byte = {7'h00, irq_status_ff};
    assign rd_mask_byte   = {7'h00, irq_mask_ff};

    // Read selection; hits never overlap, unmapped words read zero
    assign rd_byte =
        hit_ctrl ? rd_ctrl_byte :
        hit_rl   ? reload_low_byte_ff :
        hit_rh   ? reload_high_byte_ff :
        hit_cl   ? count[7:0] :
        hit_ch   ? count[15:8] :
        hit_st   ? rd_status_byte :
        hit_mk   ? rd_mask_byte : 8'h00;
    assign nxt_readdata = {24'h00_0000, rd_byte};

    // Wait-state flop
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;
        end
    end

    // Read data captured in the wait cycle so it stands in the answered cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            readdata_ff <= 32'h0000_0000;
        end else begin
            readdata_ff <= rd_capture ? nxt_readdata : readdata_ff;
        end
    end

    // Control byte
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= rtb_pkg::RST_TIMER_CONTROL;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Overflow flag
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            overflow_flag_ff <= 1'b0;
        end else begin
            overflow_flag_ff <= nxt_overflow_flag;
        end
    end

    // Sticky interrupt status
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_status_ff <= 1'b0;
        end else begin
            irq_status_ff <= nxt_irq_status;
        end
    end

    // Interrupt mask; starts masked so nothing fires before software is ready
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_mask_ff <= rtb_pkg::RST_IRQ_MASK;
        end else begin
            irq_mask_ff <= nxt_irq_mask;
        end
    end

    // Reload low byte; writing while running is not guarded, software must halt first
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reload_low_byte_ff <= rtb_pkg::RST_RELOAD;
        end else begin
            reload_low_byte_ff <= nxt_reload_low;
        end
    end

    // Reload high byte, same hazard as the low byte
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reload_high_byte_ff <= rtb_pkg::RST_RELOAD;
        end else begin
            reload_high_byte_ff <= nxt_reload_high;
        end
    end

    assign readdata = readdata_ff;
    assign irq      = irq_status_ff & irq_mask_ff;
    assign timer_int_request = overflow_flag_ff & timer_int_enable;

    // Serial port steering
    assign port0_baud_source_select = ctrl_ff[rtb_pkg::POS_BAUD_SRC];
    assign port0_baud_tick = port0_baud_source_select ? overflow : timer1_baud_tick;
    assign port1_double_baud = ctrl_ff[rtb_pkg::POS_DOUBLE_BAUD];
    assign port1_double_active =
        port1_double_baud & (port1_mode == rtb_pkg::PORT1_MODE_DOUBLE);
    assign port1_frame_error_access = ctrl_ff[rtb_pkg::POS_FE_ACCESS];
    assign port1_ctrl_bit7 =
        port1_frame_error_access ? port1_framing_error : port1_mode_bit_zero;
endmodule

//--- rtb_pkg.sv
// Functional notes
// - Count clock is system clock divided by 1,2,4..128 from the 3-bit prescale code.
// - Run bit clear stops and holds the count; run bit set lets it count.
// - Overflow flag is set whenever the 16-bit count overflows.
// - Reload low byte gives the low eight reload bits and resets to zero.
// - Reload high byte gives the upper eight reload bits and resets to zero.
// - Baud source bit picks timer 1 (0) or this timer (1) for port 0 modes 1 and 3.
// - Double-baud bit doubles serial port 1 baud rate while that port is in mode 2.
// - Frame-error access bit steers port 1 control bit 7 to mode bit 0 or framing error.
package rtb_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_TIMER_CONTROL = 8'hC4;
    localparam logic [7:0] IDX_RELOAD_LOW    = 8'hC5;
    localparam logic [7:0] IDX_RELOAD_HIGH   = 8'hC6;
    localparam logic [7:0] IDX_COUNT_LOW     = 8'hD0;
    localparam logic [7:0] IDX_COUNT_HIGH    = 8'hD1;
    localparam logic [7:0] IDX_IRQ_STATUS    = 8'hD2;
    localparam logic [7:0] IDX_IRQ_MASK      = 8'hD3;

    // Control register field positions
    localparam int POS_DOUBLE_BAUD = 7;
    localparam int POS_FE_ACCESS   = 6;
    localparam int POS_BAUD_SRC    = 5;
    localparam int POS_OVF_FLAG    = 4;
    localparam int POS_RUN         = 3;
    localparam int POS_PRESCALE    = 0;
    localparam int PRESCALE_W      = 3;

    // Reset values
    localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] RST_RELOAD        = 8'h00;
    localparam logic [0:0] RST_IRQ_MASK      = 1'h0;

    // Serial port 1 mode in which doubling applies
    localparam logic [1:0] PORT1_MODE_DOUBLE = 2'h2;

    // Widths
    localparam int COUNT_W  = 16;
    localparam int DIVCNT_W = 7;

endpackage

//--- rtb_presc_if.sv
// Prescaler control and tick between the top and the divider
interface rtb_presc_if;
    logic       run;
    logic [2:0] sel;
    logic       tick;

    modport ctrl (output run, output sel, input tick);
    modport presc (input run, input sel, output tick);
endinterface

//--- rtb_prescaler.sv
// Divides the system clock by 2**sel into one-cycle count ticks
module rtb_prescaler (
    input  wire logic   clock,
    input  wire logic   resetn,
    rtb_presc_if.presc  pif
);
    logic [rtb_pkg::DIVCNT_W-1:0] div_ff;
    logic [rtb_pkg::DIVCNT_W-1:0] nxt_div;
    logic [rtb_pkg::DIVCNT_W-1:0] mask;
    logic                          wrap;

    // Mask of low bits that must all be set before a tick
    assign mask    = rtb_pkg::DIVCNT_W'((8'h01 << pif.sel) - 8'h01);
    assign wrap    = ((div_ff & mask) == mask);
    assign pif.tick = pif.run & wrap;
    // Halted divider restarts from zero so the first period is whole
    assign nxt_div = (!pif.run || wrap) ? '0 : div_ff + 1'b1;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end
endmodule

//--- rtb_counter.sv
// Up counter that reloads on overflow
module rtb_counter #(
    parameter int WIDTH = rtb_pkg::COUNT_W
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic             tick,
    input  wire logic [WIDTH-1:0] reload,
    output logic      [WIDTH-1:0] count,
    output logic                  overflow
);
    logic [WIDTH-1:0] cnt_ff;
    logic [WIDTH-1:0] nxt_cnt;

    // Overflow is the tick that would roll past all ones
    assign overflow = tick & (&cnt_ff);
    assign nxt_cnt  = overflow ? reload : (tick ? cnt_ff + 1'b1 : cnt_ff);
    assign count    = cnt_ff;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule

//--- rtb_timer_monitor.sv
module rtb_timer_monitor (
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic       read,
    input wire logic       write,
    input wire logic       waitrequest,
    input wire logic       timer_int_enable,
    input wire logic       timer_int_request,
    input wire logic       timer1_baud_tick,
    input wire logic       port0_baud_tick,
    input wire logic       port0_baud_source_select,
    input wire logic [1:0] port1_mode,
    input wire logic       port1_double_baud,
    input wire logic       port1_double_active,
    input wire logic       port1_frame_error_access,
    input wire logic       port1_mode_bit_zero,
    input wire logic       port1_framing_error,
    input wire logic       port1_ctrl_bit7
);
    timeunit 1ns;
    timeprecision 1ps;

    // All checks live in the one system clock domain
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // Bus handshake: exactly one wait cycle, none while idle
    a_wait_first_cycle: assert property ((read || write) && !$past(read || write) |-> waitrequest)
        else $error("no wait on first request cycle");
    a_wait_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("wait held beyond one cycle");
    a_idle_no_wait: assert property (!(read || write) |-> !waitrequest)
        else $error("wait raised while idle");
    // Baud and serial steering
    a_baud_from_timer1: assert property (
        !port0_baud_source_select |-> port0_baud_tick == timer1_baud_tick)
        else $error("port0 baud not from timer 1");
    a_double_qualified: assert property (
        port1_double_active ==
        (port1_double_baud && port1_mode == rtb_pkg::PORT1_MODE_DOUBLE))
        else $error("double baud qualification wrong");
    a_port1_steer: assert property (
        port1_ctrl_bit7 ==
        (port1_frame_error_access ? port1_framing_error : port1_mode_bit_zero))
        else $error("port1 bit7 steering wrong");
    // Overflow flag feeds the interrupt request one edge later, if still enabled then
    a_flag_sets_request: assert property (
        port0_baud_source_select && port0_baud_tick ##1 timer_int_enable |-> timer_int_request)
        else $error("overflow did not raise request");
    a_request_needs_enable: assert property (timer_int_request |-> timer_int_enable)
        else $error("request without enable");

    cover property (port0_baud_source_select && port0_baud_tick);
    cover property (timer_int_request);
    cover property (port1_double_active);
endmodule

bind rtb_timer rtb_timer_monitor i_monitor (
    .clock                    (clock),
    .resetn                   (resetn),
    .read                     (read),
    .write                    (write),
    .waitrequest              (waitrequest),
    .timer_int_enable         (timer_int_enable),
    .timer_int_request        (timer_int_request),
    .timer1_baud_tick         (timer1_baud_tick),
    .port0_baud_tick          (port0_baud_tick),
    .port0_baud_source_select (port0_baud_source_select),
    .port1_mode               (port1_mode),
    .port1_double_baud        (port1_double_baud),
    .port1_double_active      (port1_double_active),
    .port1_frame_error_access (port1_frame_error_access),
    .port1_mode_bit_zero      (port1_mode_bit_zero),
    .port1_framing_error      (port1_framing_error),
    .port1_ctrl_bit7          (port1_ctrl_bit7)
);

//--- tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, resetn, read, write, waitrequest, irq, timer_int_enable, isr_enter;
    logic        timer_int_request, timer1_baud_tick, port0_baud_tick, port0_baud_source_select;
    logic        port1_double_baud, port1_double_active, port1_frame_error_access;
    logic        port1_mode_bit_zero, port1_framing_error, port1_ctrl_bit7;
    logic [1:0]  port1_mode;
    logic [3:0]  byteenable;
    logic [9:0]  address;
    logic [31:0] writedata, readdata;
    logic [7:0]  lfsr, q, ctrl_m, rl_m, rh_m;
    int          num_errors, checked, n, code;

    rtb_timer i_dut (
        .clock                    (clock),
        .resetn                   (resetn),
        .address                  (address),
        .read                     (read),
        .write                    (write),
        .writedata                (writedata),
        .byteenable               (byteenable),
        .readdata                 (readdata),
        .waitrequest              (waitrequest),
        .irq                      (irq),
        .timer_int_enable         (timer_int_enable),
        .isr_enter                (isr_enter),
        .timer_int_request        (timer_int_request),
        .timer1_baud_tick         (timer1_baud_tick),
        .port0_baud_tick          (port0_baud_tick),
        .port0_baud_source_select (port0_baud_source_select),
        .port1_mode               (port1_mode),
        .port1_double_baud        (port1_double_baud),
        .port1_double_active      (port1_double_active),
        .port1_frame_error_access (port1_frame_error_access),
        .port1_mode_bit_zero      (port1_mode_bit_zero),
        .port1_framing_error      (port1_framing_error),
        .port1_ctrl_bit7          (port1_ctrl_bit7)
    );

    // Free-running 100 MHz clock
    initial clock = 1'h0;
    always #5 clock = ~clock;

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One Avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                       output logic [7:0] rq);
        int k;
        k = 0;
        @(posedge clock);
        address   <= {idx, 2'h0};
        writedata <= {24'h0, d};
        write     <= wr;
        read      <= !wr;
        // Sampled at each rising edge; the answer edge is the one that sees wait low
        do begin
            @(posedge clock);
            k++;
        end while (waitrequest !== 1'h0 && k < 50);
        if (k >= 50) num_errors++;
        rq = readdata[7:0];
        read  <= 1'h0;
        write <= 1'h0;
    endtask

    // Cycles up to the next overflow pulse on the baud output
    task automatic wait_tick(output int cnt);
        cnt = 0;
        do begin
            @(negedge clock);
            cnt++;
        end while (port0_baud_tick !== 1'h1 && cnt < 70000);
    endtask

    task automatic stop_test;
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog: one 65536-tick first period plus about 8k cycles of the rest
    initial begin
        repeat (95000) @(posedge clock);
        num_errors++;
        stop_test();
    end

    initial begin
        {resetn, read, write, isr_enter, timer1_baud_tick} = '0;
        {port1_mode, port1_mode_bit_zero, port1_framing_error} = '0;
        timer_int_enable = 1'h1;
        address = '0;
        writedata = '0;
        byteenable = 4'hF;
        num_errors = 0;
        checked = 0;
        lfsr = 8'h3A;
        repeat (5) @(posedge clock);
        resetn <= 1'h1;
        // Reset state, unmapped place, reload written while halted
        bus(1'h0, rtb_pkg::IDX_RELOAD_LOW, 8'h00, q);
        check_val("reload_low", 8'h00, q);
        bus(1'h0, rtb_pkg::IDX_RELOAD_HIGH, 8'h00, q);
        check_val("reload_high", 8'h00, q);
        bus(1'h0, 8'h40, 8'h00, q);
        check_val("unmapped", 8'h00, q);
        rl_m = 8'hF0;
        rh_m = 8'hFF;
        bus(1'h1, rtb_pkg::IDX_RELOAD_LOW, rl_m, q);
        bus(1'h1, rtb_pkg::IDX_RELOAD_HIGH, rh_m, q);
        // Every prescale code, period between reloaded overflows
        for (code = 0; code < 8; code++) begin
            ctrl_m = 8'h28 | 8'(code);
            bus(1'h1, rtb_pkg::IDX_TIMER_CONTROL, ctrl_m, q);
            wait_tick(n);
            wait_tick(n);
            check_val("period", (32'h10000 - {16'h0, rh_m, rl_m}) << code, n);
        end
        // Halt with divide-by-1: any missed halt shows at once
        bus(1'h1, rtb_pkg::IDX_TIMER_CONTROL, 8'h10, q);
        bus(1'h0, rtb_pkg::IDX_COUNT_LOW, 8'h00, ctrl_m);
        repeat (40) @(posedge clock);
        bus(1'h0, rtb_pkg::IDX_COUNT_LOW, 8'h00, q);
        check_val("held_count", ctrl_m, q);
        bus(1'h0, rtb_pkg::IDX_TIMER_CONTROL, 8'h00, q);
        check_val("control", 8'h10, q);
        check_val("int_request", 1'h1, timer_int_request);
        @(posedge clock);
        isr_enter <= 1'h1;
        @(posedge clock);
        isr_enter <= 1'h0;
        bus(1'h0, rtb_pkg::IDX_TIMER_CONTROL, 8'h00, q);
        check_val("control_isr", 8'h00, q);
        // Sticky status, mask, read clear
        check_val("irq_masked", 1'h0, irq);
        bus(1'h1, rtb_pkg::IDX_IRQ_MASK, 8'h01, q);
        @(negedge clock);
        check_val("irq", 1'h1, irq);
        bus(1'h0, rtb_pkg::IDX_IRQ_STATUS, 8'h00, q);
        check_val("status", 8'h01, q);
        @(negedge clock);
        check_val("irq_cleared", 1'h0, irq);
        // Random serial selects and inputs, flag set by software
        repeat (8) begin
            lfsr = lfsr_next(lfsr);
            ctrl_m = (lfsr & 8'hE0) | 8'h10;
            bus(1'h1, rtb_pkg::IDX_TIMER_CONTROL, ctrl_m, q);
            {timer_int_enable, port1_mode, port1_mode_bit_zero, port1_framing_error} <= lfsr[5:1];
            timer1_baud_tick <= lfsr[0];
            @(negedge clock);
            check_val("double_active", ctrl_m[7] && lfsr[4:3] == 2'h2, port1_double_active);
            check_val("ctrl_bit7", ctrl_m[6] ? lfsr[1] : lfsr[2], port1_ctrl_bit7);
            check_val("baud_tick", ctrl_m[5] ? 1'h0 : lfsr[0], port0_baud_tick);
            check_val("baud_source", ctrl_m[5], port0_baud_source_select);
            check_val("double_baud", ctrl_m[7], port1_double_baud);
            check_val("fe_access", ctrl_m[6], port1_frame_error_access);
            check_val("int_request", lfsr[5], timer_int_request);
        end
        // Software clears the flag it set
        bus(1'h1, rtb_pkg::IDX_TIMER_CONTROL, 8'h00, q);
        bus(1'h0, rtb_pkg::IDX_TIMER_CONTROL, 8'h00, q);
        check_val("control_clear", 8'h00, q);
        check_val("int_cleared", 1'h0, timer_int_request);
        stop_test();
    end
endmodule
